/* File: swing_supervisor.sv */
// Power swing block and out-of-step supervisor with AXI4-Lite registers.
// Assumes measurements come from logic on aclk, updated every cycle.
`timescale 1ns/100ps
`default_nettype none
module swing_supervisor #(
   parameter int WIN_CYC = swing_pkg::SWING_WIN_CYC,
   parameter int HOLD_CYC = swing_pkg::OOS_HOLD_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [swing_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [swing_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic signed [15:0] imp_r,
   input wire logic signed [15:0] imp_x,
   input wire logic [7:0] sequence_unbalance_ratio,
   input wire logic [7:0] calculated_residual_current,
   input wire logic [15:0] sc_current,
   input wire logic fault_active,
   output logic swing_block,
   output logic [7:0] zone_block,
   output logic out_of_step,
   output logic oos_trip,
   output logic low_current_block
);
   typedef struct packed {
      swing_pkg::swing_st_t st;
      logic [swing_pkg::CNT_W-1:0] wcnt;
      logic oos;
      logic [swing_pkg::CNT_W-1:0] ocnt;
      logic blk;
      logic [7:0] zblk;
      logic trip;
      logic lcb;
      logic aw_got;
      logic w_got;
      logic [swing_pkg::ADDR_W-1:0] awa;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [swing_pkg::NCFG-1:0][31:0] cfg;
   } state_t;

   localparam logic [swing_pkg::CNT_W-1:0] WIN_LAST = swing_pkg::CNT_W'(WIN_CYC - 1);
   localparam logic [swing_pkg::CNT_W-1:0] HOLD_LAST = swing_pkg::CNT_W'(HOLD_CYC - 1);

   state_t q;
   state_t d;
   logic en;
   logic quiet;
   logic [3:0] widx;
   logic [3:0] ridx;
   char_if ci();

   function automatic logic [3:0] reg_idx(input logic [swing_pkg::ADDR_W-1:0] a);
      reg_idx = (a[7:6] == 2'h0) ? a[5:2] : 4'hF;
   endfunction

   assign ci.imp_r = imp_r;
   assign ci.imp_x = imp_x;
   assign ci.set_r = q.cfg[swing_pkg::IDX_ZONE_R][15:0];
   assign ci.set_x = q.cfg[swing_pkg::IDX_ZONE_X][15:0];
   assign ci.margin = q.cfg[swing_pkg::IDX_MARGIN][15:0];
   assign ci.tol_pct = q.cfg[swing_pkg::IDX_TOL][7:0];
   assign ci.load_r = q.cfg[swing_pkg::IDX_LOAD_R][15:0];
   assign ci.load_slope = q.cfg[swing_pkg::IDX_LOAD_SLOPE][7:0];
   assign ci.load_en = q.cfg[swing_pkg::IDX_CTRL][swing_pkg::CTRL_LOAD_BIT];
   assign ci.char_type = q.cfg[swing_pkg::IDX_CTRL][swing_pkg::CTRL_TYPE_LSB +: 2];

   quad_char u_char (
      .c(ci.eval)
   );

   assign en = q.cfg[swing_pkg::IDX_CTRL][swing_pkg::CTRL_EN_BIT];
   // Fixed unbalance and residual limits
   assign quiet = (sequence_unbalance_ratio < swing_pkg::UNBAL_LIMIT_PCT)
      && (calculated_residual_current < swing_pkg::RESID_LIMIT_PCT);
   assign widx = reg_idx(q.awa);
   assign ridx = reg_idx(araddr);

   assign awready = !q.aw_got && !q.bvalid;
   assign wready = !q.w_got && !q.bvalid;
   assign arready = !q.rvalid;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign swing_block = q.blk;
   assign zone_block = q.zblk;
   assign out_of_step = q.oos;
   assign oos_trip = q.trip;
   assign low_current_block = q.lcb;

   always_comb begin
      d = q;
      // Write channel
      if (awvalid && awready) begin
         d.aw_got = 1'b1;
         d.awa = awaddr;
      end
      if (wvalid && wready) begin
         d.w_got = 1'b1;
         d.wd = wdata;
         d.ws = wstrb;
      end
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = swing_pkg::RESP_SLVERR;
         if (widx < 4'(swing_pkg::NCFG)) begin
            d.bresp = swing_pkg::RESP_OKAY;
            for (int b = 0; b < 4; b++) begin
               if (q.ws[b]) begin
                  d.cfg[widx[2:0]][8*b +: 8] = q.wd[8*b +: 8] & swing_pkg::CFG_WMASK[widx[2:0]][8*b +: 8];
               end
            end
         end
      end
      // Read channel
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         d.rvalid = 1'b1;
         d.rresp = swing_pkg::RESP_OKAY;
         d.rdata = 32'h00000000;
         if (ridx < 4'(swing_pkg::NCFG)) begin
            d.rdata = q.cfg[ridx[2:0]];
         end else if (ridx == swing_pkg::IDX_STATUS) begin
            d.rdata = {25'h0, q.lcb, q.oos, q.blk, q.st};
         end else begin
            d.rresp = swing_pkg::RESP_SLVERR;
         end
      end
      // Out-of-step hold timer
      if (q.oos) begin
         if (q.ocnt == HOLD_LAST) begin
            d.oos = 1'b0;
         end else begin
            d.ocnt = q.ocnt + 1'b1;
         end
      end
      // Swing trajectory tracking
      unique case (q.st)
         swing_pkg::ST_IDLE: begin
            if (ci.in_band && !ci.in_zone && !fault_active) begin
               d.st = swing_pkg::ST_BAND;
               d.wcnt = '0;
            end
         end
         swing_pkg::ST_BAND: begin
            if (q.wcnt != WIN_LAST) begin
               d.wcnt = q.wcnt + 1'b1;
            end
            if (fault_active || !ci.in_band) begin
               d.st = swing_pkg::ST_IDLE;
            end else if (ci.in_zone) begin
               // Slow crossing blocks, fast one trips
               d.st = (q.wcnt == WIN_LAST && quiet) ? swing_pkg::ST_BLOCK : swing_pkg::ST_IDLE;
            end
         end
         swing_pkg::ST_BLOCK: begin
            // Held inside zone until exit or fault
            if (fault_active) begin
               d.st = swing_pkg::ST_IDLE;
            end else if (!ci.in_zone) begin
               d.st = swing_pkg::ST_EXIT;
            end
         end
         swing_pkg::ST_EXIT: begin
            if (fault_active) begin
               d.st = swing_pkg::ST_IDLE;
            end else if (ci.in_zone) begin
               d.st = swing_pkg::ST_BLOCK;
            end else if (!ci.in_band) begin
               // Quadrant I exit stays a swing, II is out-of-step
               d.st = swing_pkg::ST_IDLE;
               if (ci.quad2) begin
                  d.oos = 1'b1;
                  d.ocnt = '0;
               end
            end
         end
         default: begin
            d.st = swing_pkg::ST_IDLE;
         end
      endcase
      // Disabled function is silent
      if (!en) begin
         d.st = swing_pkg::ST_IDLE;
         d.oos = 1'b0;
      end
      d.blk = (d.st == swing_pkg::ST_BLOCK);
      // Block matrix and output matrix
      d.zblk = d.blk ? q.cfg[swing_pkg::IDX_CTRL][swing_pkg::CTRL_MATRIX_LSB +: 8] : 8'h00;
      d.trip = d.oos && q.cfg[swing_pkg::IDX_CTRL][swing_pkg::CTRL_OOSTRIP_BIT];
      // Low-current blocking
      d.lcb = sc_current < q.cfg[swing_pkg::IDX_LC_THR][15:0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.st <= swing_pkg::ST_RST;
         q.cfg <= {swing_pkg::NCFG{swing_pkg::CFG_RST}};
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_off_quiet;
      !en |=> !swing_block && !out_of_step;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("Output active while disabled");

   property p_slow_block;
      en && q.st == swing_pkg::ST_BAND && ci.in_band && ci.in_zone && !fault_active
         && q.wcnt == WIN_LAST && quiet |=> swing_block;
   endproperty
   a_slow_block: assert property (p_slow_block) else $error("Slow crossing not blocked");

   property p_fast_free;
      q.st == swing_pkg::ST_BAND && ci.in_zone && q.wcnt != WIN_LAST |=> !swing_block;
   endproperty
   a_fast_free: assert property (p_fast_free) else $error("Fast crossing blocked");

   property p_matrix;
      !swing_block |-> zone_block == 8'h00;
   endproperty
   a_matrix: assert property (p_matrix) else $error("Zone blocked without swing");

   property p_oos_edge;
      $rose(out_of_step) |-> $past(q.st == swing_pkg::ST_EXIT && !ci.in_band && ci.quad2);
   endproperty
   a_oos_edge: assert property (p_oos_edge) else $error("Out-of-step not at band edge");

   property p_oos_len;
      $fell(out_of_step) && $past(en) |-> $past(q.ocnt) == HOLD_LAST;
   endproperty
   a_oos_len: assert property (p_oos_len) else $error("Out-of-step hold length wrong");

   property p_trip_map;
      oos_trip |-> out_of_step;
   endproperty
   a_trip_map: assert property (p_trip_map) else $error("Trip without out-of-step");

   property p_hold;
      en && swing_block && q.st == swing_pkg::ST_BLOCK && ci.in_zone && !fault_active |=> swing_block;
   endproperty
   a_hold: assert property (p_hold) else $error("Block dropped inside zone");

   property p_quiet_needed;
      $rose(swing_block) |-> $past(quiet) || $past(q.st == swing_pkg::ST_EXIT);
   endproperty
   a_quiet_needed: assert property (p_quiet_needed) else $error("Block with unbalance");

   property p_fault_release;
      q.st == swing_pkg::ST_BLOCK && fault_active |=> !swing_block ##1 !swing_block || fault_active;
   endproperty
   a_fault_release: assert property (p_fault_release) else $error("Fault did not release block");

   property p_low_cur;
      $past(aresetn) |-> low_current_block == $past(sc_current < q.cfg[swing_pkg::IDX_LC_THR][15:0]);
   endproperty
   a_low_cur: assert property (p_low_cur) else $error("Low-current block wrong");

   c_block: cover property ($rose(swing_block));
   c_oos: cover property ($rose(out_of_step));
   c_fast: cover property (q.st == swing_pkg::ST_BAND ##1 q.st == swing_pkg::ST_IDLE && !swing_block);
   c_fault: cover property (swing_block && fault_active);
endmodule
`default_nettype wire

/* File: swing_pkg.sv */
// Constants, register map and types of the power swing supervisor.
// Assumes a single 125 MHz clock and a 32-bit AXI4-Lite register bus.
// Overview of operation
// - Swing detection runs only while its enable bit is set.
// - Band spans from largest zone edge to margin impedance further out.
// - Block only when band crossing takes at least the fixed 40 ms.
// - Faster crossing gives no block, so zones trip normally.
// - Block reaches only the zones selected in the block matrix.
// - Out-of-step is raised at the outer band edge.
// - Out-of-step is offered to the output matrix for tripping.
// - Leaving the zone through quadrant I keeps it a power swing.
// - Block holds while trajectory stays inside the zone without fault.
// - Exit through quadrant II raises out-of-step for 0.5 s.
// - Quadrants I and III are treated alike, non-directional.
// - Block also needs unbalance below 25% and residual below 10%.
// - Low-current block while short-circuit current is below threshold.
// - Load resistance and angle apply only with load block in use.
// - Reach tolerance is the percentage of the larger of R and X.
// - Line angle 90 degrees for types 1 and 2, 75 for 3 and 4.
// - With R above X, quadrant II resistive reach is shorter.
package swing_pkg;
   localparam int CLK_MHZ = 125;
   localparam int SWING_WIN_MS = 40;
   localparam int SWING_WIN_CYC = SWING_WIN_MS * CLK_MHZ * 1000;
   localparam int OOS_HOLD_MS = 500;
   localparam int OOS_HOLD_CYC = OOS_HOLD_MS * CLK_MHZ * 1000;
   localparam int CNT_W = 26;
   localparam int ADDR_W = 8;
   localparam logic [7:0] UNBAL_LIMIT_PCT = 8'h19;
   localparam logic [7:0] RESID_LIMIT_PCT = 8'h0A;
   localparam logic [8:0] TAN15_Q8 = 9'h045;
   localparam logic [10:0] DIV100_MUL = 11'h51F;
   localparam int DIV100_SHIFT = 17;
   localparam int NCFG = 8;
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_MARGIN = 4'h1;
   localparam logic [3:0] IDX_ZONE_R = 4'h2;
   localparam logic [3:0] IDX_ZONE_X = 4'h3;
   localparam logic [3:0] IDX_TOL = 4'h4;
   localparam logic [3:0] IDX_LOAD_R = 4'h5;
   localparam logic [3:0] IDX_LOAD_SLOPE = 4'h6;
   localparam logic [3:0] IDX_LC_THR = 4'h7;
   localparam logic [3:0] IDX_STATUS = 4'h8;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_LOAD_BIT = 1;
   localparam int CTRL_TYPE_LSB = 2;
   localparam int CTRL_MATRIX_LSB = 8;
   localparam int CTRL_OOSTRIP_BIT = 16;
   localparam logic [NCFG-1:0][31:0] CFG_WMASK = {
      32'h0000FFFF, 32'h000000FF, 32'h0000FFFF, 32'h000000FF,
      32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h0001FF0F};
   localparam logic [31:0] CFG_RST = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_BAND = 4'h2,
      ST_BLOCK = 4'h4,
      ST_EXIT = 4'h8
   } swing_st_t;
   localparam swing_st_t ST_RST = ST_IDLE;
endpackage

/* File: char_if.sv */
// Carrier between the supervisor and its characteristic evaluator.
// Assumes purely combinational evaluation on the supervisor's clock.
`timescale 1ns/100ps
`default_nettype none
interface char_if;
   logic signed [15:0] imp_r;
   logic signed [15:0] imp_x;
   logic [15:0] set_r;
   logic [15:0] set_x;
   logic [15:0] margin;
   logic [15:0] load_r;
   logic [7:0] load_slope;
   logic [7:0] tol_pct;
   logic [1:0] char_type;
   logic load_en;
   logic in_zone;
   logic in_band;
   logic quad2;
   modport eval (input imp_r, imp_x, set_r, set_x, margin, load_r, load_slope, tol_pct,
      char_type, load_en, output in_zone, in_band, quad2);
   modport user (output imp_r, imp_x, set_r, set_x, margin, load_r, load_slope, tol_pct,
      char_type, load_en, input in_zone, in_band, quad2);
endinterface
`default_nettype wire

/* File: quad_char.sv */
// Quadrilateral zone and swing band evaluator.
// Assumes settings and impedance are stable within the cycle.
`timescale 1ns/100ps
`default_nettype none
module quad_char (
   char_if.eval c
);
   logic neg;
   logic signed [19:0] rr;
   logic signed [19:0] xx;
   logic [15:0] big;
   logic [34:0] prod;
   logic signed [19:0] tol;
   logic signed [19:0] sh;
   logic signed [19:0] rq1;
   logic signed [19:0] rq2;
   logic signed [19:0] xq;
   logic signed [19:0] m;
   logic load;
   logic signed [27:0] lx;
   logic signed [27:0] lr;

   function automatic logic inside_q(input logic signed [19:0] r, input logic signed [19:0] x,
      input logic signed [19:0] r1, input logic signed [19:0] r2, input logic signed [19:0] xl);
      inside_q = (x <= xl) && ((r >= 0) ? (r <= r1) : (-r <= r2));
   endfunction

   always_comb begin
      // Mirror quadrant III onto I
      neg = c.imp_x[15];
      rr = neg ? -20'(c.imp_r) : 20'(c.imp_r);
      xx = neg ? -20'(c.imp_x) : 20'(c.imp_x);
      // Tolerance from the larger setting
      big = (c.set_r > c.set_x) ? c.set_r : c.set_x;
      prod = 35'(c.tol_pct) * 35'(big) * 35'(swing_pkg::DIV100_MUL);
      tol = 20'(prod >> swing_pkg::DIV100_SHIFT);
      // 75 degree line tilts both resistive edges
      sh = c.char_type[1] ? 20'((28'(xx) * 28'(swing_pkg::TAN15_Q8)) >>> 8) : 20'sh0;
      xq = $signed({4'h0, c.set_x}) + tol;
      rq1 = $signed({4'h0, c.set_r}) + tol + sh;
      // Shorter quadrant II reach when R exceeds X
      rq2 = ((c.set_r > c.set_x) ? $signed({5'h0, c.set_r[15:1]}) : $signed({4'h0, c.set_r}))
         + tol - sh;
      // Load encroachment only when selected
      lx = 28'(xx) <<< 8;
      lr = 28'(rr) * $signed({20'h0, c.load_slope});
      load = c.load_en && (rr > 0) && (rr >= $signed({4'h0, c.load_r})) && (lx <= lr);
      m = $signed({4'h0, c.margin});
      c.in_zone = inside_q(rr, xx, rq1, rq2, xq) && !load;
      // Band outer edge lies margin beyond the zone
      c.in_band = inside_q(rr, xx, rq1 + m, rq2 + m, xq + m) && !load;
      c.quad2 = rr < 0;
   end
endmodule
`default_nettype wire

/* File: meas_model.sv */
// Far-side model: impedance measurement path feeding the supervisor.
// Assumes bench calls its tasks; values change right after rising edges.
`timescale 1ns/100ps
`default_nettype none
module meas_model (
   input wire logic aclk,
   output logic signed [15:0] imp_r,
   output logic signed [15:0] imp_x,
   output logic [7:0] unbal,
   output logic [7:0] resid,
   output logic [15:0] sc_cur,
   output logic fault
);
   initial begin
      imp_r = 16'sh0010;
      imp_x = 16'sh00C8;
      unbal = 8'h00;
      resid = 8'h00;
      sc_cur = 16'h0200;
      fault = 1'b0;
   end
   // Moves trajectory to a point and dwells n cycles
   task automatic step(input logic signed [15:0] r, input logic signed [15:0] x, input int n);
      @(posedge aclk);
      imp_r <= r;
      imp_x <= x;
      repeat (n - 1) @(posedge aclk);
   endtask
   // Current conditions and fault detection
   task automatic cond(input logic [7:0] u, input logic [7:0] e, input logic [15:0] s, input logic f);
      @(posedge aclk);
      unbal <= u;
      resid <= e;
      sc_cur <= s;
      fault <= f;
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the swing supervisor.
// Assumes meas_model drives the measurements; registers via AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int WIN = 20;
   localparam int HOLD = 30;
   localparam logic [7:0] UB[3] = '{8'h18, 8'h19, 8'h00};
   localparam logic [7:0] RS[3] = '{8'h09, 8'h00, 8'h0A};
   localparam logic EB[3] = '{1'b1, 1'b0, 1'b0};
   logic aclk, aresetn;
   logic [7:0] awaddr, araddr, unbal, resid, zone_block;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic signed [15:0] imp_r, imp_x;
   logic [15:0] sc_cur;
   logic fault, swing_block, out_of_step, oos_trip, low_current_block, trip_seen;
   int miscompares, check_count, k;
   swing_supervisor #(.WIN_CYC(WIN), .HOLD_CYC(HOLD)) DUT (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .imp_r(imp_r), .imp_x(imp_x),
      .sequence_unbalance_ratio(unbal), .calculated_residual_current(resid),
      .sc_current(sc_cur), .fault_active(fault), .swing_block(swing_block),
      .zone_block(zone_block), .out_of_step(out_of_step), .oos_trip(oos_trip),
      .low_current_block(low_current_block));
   meas_model M (.aclk(aclk), .imp_r(imp_r), .imp_x(imp_x), .unbal(unbal), .resid(resid),
      .sc_cur(sc_cur), .fault(fault));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   function automatic logic [7:0] ad(input logic [3:0] i);
      return {2'h0, i, 2'h0};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic ap, wp, ta, tw;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ap = 1'b1;
      wp = 1'b1;
      n = 0;
      while ((ap || wp) && n < 50) begin
         @(negedge aclk);
         ta = ap && awready;
         tw = wp && wready;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            ap = 1'b0;
         end
         if (tw) begin
            wvalid <= 1'b0;
            wp = 1'b0;
         end
         n++;
      end
      while (n < 50) begin
         @(negedge aclk);
         if (bvalid === 1'b1)
            break;
         @(posedge aclk);
         n++;
      end
      if (n >= 50) begin
         miscompares++;
         tally_and_finish();
      end
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      t = 1'b0;
      n = 0;
      while (!t && n < 50) begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
         n++;
      end
      arvalid <= 1'b0;
      while (n < 50) begin
         @(negedge aclk);
         if (rvalid === 1'b1)
            break;
         @(posedge aclk);
         n++;
      end
      if (n >= 50) begin
         miscompares++;
         tally_and_finish();
      end
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   // Approach from outside, dwell in band, then enter the zone
   task automatic swing(input logic signed [15:0] br, input logic signed [15:0] bx, input int bn,
         input logic signed [15:0] zr, input logic signed [15:0] zx, input logic eb);
      M.step(16'sh0010, 16'sh00C8, 4);
      M.step(br, bx, bn);
      M.step(zr, zx, 4);
      @(negedge aclk);
      chk({31'h0, swing_block}, {31'h0, eb});
      chk({24'h0, zone_block}, eb ? 32'h000000A5 : 32'h00000000);
   endtask
   initial begin
      repeat (100000) @(posedge aclk);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      miscompares = 0;
      check_count = 0;
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ad(swing_pkg::IDX_CTRL), 32'h00000000, swing_pkg::RESP_OKAY);
      rd(ad(swing_pkg::IDX_STATUS), 32'h00000001, swing_pkg::RESP_OKAY);
      rd(8'h24, 32'h00000000, swing_pkg::RESP_SLVERR);
      wr(ad(swing_pkg::IDX_STATUS), 32'h0000000F, swing_pkg::RESP_SLVERR);
      wr(ad(swing_pkg::IDX_MARGIN), 32'h00000014, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_ZONE_R), 32'h00000064, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_ZONE_X), 32'h00000064, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_LC_THR), 32'h00000100, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_CTRL), 32'h0001A501, swing_pkg::RESP_OKAY);
      rd(ad(swing_pkg::IDX_CTRL), 32'h0001A501, swing_pkg::RESP_OKAY);
      $display("test registers done");
      swing(16'sh0000, 16'sh006E, 25, 16'sh0000, 16'sh0032, 1'b1);
      M.step(16'sh0000, 16'sh0032, 40);
      chk({31'h0, swing_block}, 32'h1);
      M.cond(8'h00, 8'h00, 16'h0200, 1'b1);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk({31'h0, swing_block}, 32'h0);
      M.cond(8'h00, 8'h00, 16'h0200, 1'b0);
      swing(16'sh0000, 16'sh006E, 5, 16'sh0000, 16'sh0032, 1'b0);
      swing(16'sh0000, -16'sh006E, 25, 16'sh0000, -16'sh0032, 1'b1);
      $display("test block done");
      swing(16'sh0000, 16'sh006E, 25, 16'sh0000, 16'sh0032, 1'b1);
      M.step(-16'sh006E, 16'sh0032, 4);
      @(negedge aclk);
      chk({31'h0, out_of_step}, 32'h0);
      M.step(-16'sh00C8, 16'sh0032, 1);
      k = 0;
      while (out_of_step !== 1'b1 && k < 10) begin
         @(negedge aclk);
         k++;
      end
      if (k >= 10) begin
         miscompares++;
         tally_and_finish();
      end
      trip_seen = oos_trip;
      k = 0;
      while (out_of_step === 1'b1 && k < 100) begin
         @(negedge aclk);
         k++;
      end
      if (k >= 100) begin
         miscompares++;
         tally_and_finish();
      end
      chk({31'h0, trip_seen}, 32'h1);
      chk(k, HOLD);
      swing(16'sh0000, 16'sh006E, 25, 16'sh0000, 16'sh0032, 1'b1);
      M.step(16'sh006E, 16'sh0032, 4);
      M.step(16'sh00C8, 16'sh0032, 6);
      @(negedge aclk);
      chk({31'h0, out_of_step}, 32'h0);
      $display("test exit done");
      for (int i = 0; i < 3; i++) begin
         M.cond(UB[i], RS[i], 16'h0200, 1'b0);
         swing(16'sh0000, 16'sh006E, 25, 16'sh0000, 16'sh0032, EB[i]);
      end
      M.cond(8'h00, 8'h00, 16'h0200, 1'b0);
      for (int t = 0; t < 4; t++) begin
         wr(ad(swing_pkg::IDX_CTRL), 32'h0001A501 | (t << 2), swing_pkg::RESP_OKAY);
         swing(16'sh0000, 16'sh006E, 25, 16'sh006B, 16'sh0032, t > 1);
      end
      wr(ad(swing_pkg::IDX_CTRL), 32'h0001A501, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_ZONE_R), 32'h000000C8, swing_pkg::RESP_OKAY);
      swing(-16'sh006E, 16'sh0032, 25, -16'sh0096, 16'sh0032, 1'b0);
      wr(ad(swing_pkg::IDX_ZONE_R), 32'h00000064, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_ZONE_X), 32'h00000032, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_TOL), 32'h0000000A, swing_pkg::RESP_OKAY);
      swing(16'sh0000, 16'sh004E, 25, 16'sh0000, 16'sh001E, 1'b1);
      wr(ad(swing_pkg::IDX_ZONE_X), 32'h00000064, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_TOL), 32'h00000000, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_LOAD_R), 32'h0000003C, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_LOAD_SLOPE), 32'h00000080, swing_pkg::RESP_OKAY);
      swing(16'sh006E, 16'sh0014, 25, 16'sh0050, 16'sh0014, 1'b1);
      wr(ad(swing_pkg::IDX_CTRL), 32'h0001A503, swing_pkg::RESP_OKAY);
      swing(16'sh006E, 16'sh0014, 25, 16'sh0050, 16'sh0014, 1'b0);
      $display("test characteristic done");
      M.cond(8'h00, 8'h00, 16'h00FF, 1'b0);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk({31'h0, low_current_block}, 32'h1);
      M.cond(8'h00, 8'h00, 16'h0100, 1'b0);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk({31'h0, low_current_block}, 32'h0);
      wr(ad(swing_pkg::IDX_ZONE_R), 32'h00000064, swing_pkg::RESP_OKAY);
      wr(ad(swing_pkg::IDX_CTRL), 32'h0001A500, swing_pkg::RESP_OKAY);
      swing(16'sh0000, 16'sh006E, 25, 16'sh0000, 16'sh0032, 1'b0);
      rd(ad(swing_pkg::IDX_STATUS), 32'h00000001, swing_pkg::RESP_OKAY);
      $display("test disable done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
